/* File: design/pcipcf_pkg.sv */
// shared constants, state types and helpers for the pci port pair
package pcipcf_pkg;
  // control-line slots in the ctl vectors of the interface
  localparam int CW      = 10;
  localparam int AW      = 36;
  localparam int C_FRAME = 0;
  localparam int C_IRDY  = 1;
  localparam int C_TRDY  = 2;
  localparam int C_STOP  = 3;
  localparam int C_DEVSEL = 4;
  localparam int C_PERR  = 5;
  localparam int C_PAR   = 6;
  localparam int C_SERR  = 7;
  localparam int C_RST   = 8;
  localparam int C_INTA  = 9;
  // timing at 40 MHz
  localparam int CLK_NS    = 25;
  localparam int DEVSEL_NS = 125;
  localparam logic [2:0] DEVSEL_WAIT = 3'(DEVSEL_NS / CLK_NS);
  // command decode on cbe[3:1]
  localparam logic [2:0] CMD_MEM_HI = 3'h3;
  localparam logic [2:0] CMD_CFG_HI = 3'h5;
  // reset values and the host's own memory window
  localparam logic [31:0] WORD_RST = 32'h0;
  localparam logic [31:0] CFG_RST  = 32'h0;
  localparam logic [7:0]  HST_BASE = 8'h80;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_ADDR = 2'b01,
    M_DATA = 2'b10,
    M_REL  = 2'b11
  } pcipcf_mst_e;

  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_DATA = 2'b01,
    T_REL  = 2'b10
  } pcipcf_tgt_e;

  // byte-enable merge, enables active low
  function automatic logic [31:0] pcipcf_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  be_n);
    logic [31:0] m;
    m = {{8{~be_n[3]}}, {8{~be_n[2]}}, {8{~be_n[1]}}, {8{~be_n[0]}}};
    return (old_w & ~m) | (new_w & m);
  endfunction : pcipcf_merge
endpackage : pcipcf_pkg

/* File: design/pcipcf_if.sv */
// pci bus wires between the bridge end and the far agent end
`timescale 1ns/1ps
interface pcipcf_if;
  import pcipcf_pkg::*;
  logic [CW-1:0] dev_ctl_o;
  logic [CW-1:0] dev_ctl_oe;
  logic [CW-1:0] hst_ctl_o;
  logic [CW-1:0] hst_ctl_oe;
  logic [CW-1:0] ctl;
  logic [AW-1:0] dev_adc_o;
  logic [AW-1:0] dev_adc_oe;
  logic [AW-1:0] hst_adc_o;
  logic [AW-1:0] hst_adc_oe;
  logic [AW-1:0] adc;
  logic          idsel;
  logic          req_n;
  logic          gnt_n;

  // undriven lines float to the pull-up level
  assign ctl = (dev_ctl_oe & dev_ctl_o)
             | (~dev_ctl_oe & hst_ctl_oe & hst_ctl_o)
             | (~dev_ctl_oe & ~hst_ctl_oe);
  assign adc = (dev_adc_oe & dev_adc_o)
             | (~dev_adc_oe & hst_adc_oe & hst_adc_o)
             | (~dev_adc_oe & ~hst_adc_oe);

  modport dev (input ctl, adc, idsel, gnt_n,
               output dev_ctl_o, dev_ctl_oe, dev_adc_o, dev_adc_oe, req_n);
  modport hst (input ctl, adc, req_n,
               output hst_ctl_o, hst_ctl_oe, hst_adc_o, hst_adc_oe,
               idsel, gnt_n);
endinterface : pcipcf_if

/* File: design/pcipcf_sync.sv */
// two-flop synchroniser for strap and reset pins
`timescale 1ns/1ps
module pcipcf_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q_ff
);
  logic [W-1:0] meta_ff;

  // no reset: straps must be caught while reset is held
  always_ff @(posedge mclk) begin
    meta_ff <= d;
    q_ff    <= meta_ff;
  end
endmodule : pcipcf_sync

/* File: design/pcipcf_dev.sv */
// bridge end of the pci port: master, target, parity, arbitration, resets
`timescale 1ns/1ps
module pcipcf_dev
  import pcipcf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        cfn_strap,
  input  wire logic        processor_reset_n_i,
  output logic             processor_reset_n_o,
  output logic             processor_reset_n_oe,
  input  wire logic        int_arb,
  input  wire logic        int_gnt_n,
  input  wire logic        sw_serr,
  input  wire logic        sw_pci_rst,
  input  wire logic        doorbell_set,
  input  wire logic        outbound_pending,
  input  wire logic        mst_start,
  input  wire logic [3:0]  mst_cmd,
  input  wire logic [31:0] mst_addr,
  input  wire logic [31:0] mst_wdata,
  input  wire logic [3:0]  mst_be_n,
  output logic             mst_busy,
  output logic             mst_done,
  output logic             mst_abort,
  output logic             mst_stopped,
  output logic [31:0]      mst_rdata,
  input  wire logic [7:0]  tgt_base,
  output logic             tgt_wr,
  output logic [31:0]      tgt_word,
  output logic [31:0]      tgt_cfg,
  output logic             strap_level,
  output logic             serr_irq,
  output logic             perr_seen,
  pcipcf_if.dev            pb
);
  ////////////////////////////////////////////////////////////////////////
  logic [1:0] pin_s;
  pcipcf_sync #(.W(2)) u_sync (
    .mclk (mclk),
    .d    ({cfn_strap, processor_reset_n_i}),
    .q_ff (pin_s)
  );
  wire logic cfn_s = pin_s[1];
  wire logic prn_s = pin_s[0];

  // every line below is sampled on mclk, the pci clock
  wire logic        frame_n  = pb.ctl[C_FRAME];
  wire logic        irdy_n   = pb.ctl[C_IRDY];
  wire logic        trdy_n   = pb.ctl[C_TRDY];
  wire logic        stop_n   = pb.ctl[C_STOP];
  wire logic        devsel_n = pb.ctl[C_DEVSEL];
  wire logic        par_in   = pb.ctl[C_PAR];
  wire logic        rst_n    = pb.ctl[C_RST];
  wire logic [31:0] ad_in    = pb.adc[31:0];
  wire logic [3:0]  cbe_in   = pb.adc[35:32];
  wire logic        int_rst  = srst | ~rst_n;
  wire logic        bus_idle = frame_n & irdy_n;

  ////////////////////////////////////////////////////////////////////////
  pcipcf_mst_e m_st_ff, nxt_m_st;
  pcipcf_tgt_e t_st_ff, nxt_t_st;
  logic          m_pend_ff, m_end, m_ok, m_abt, m_stp;
  logic [3:0]    m_cmd_ff, m_be_ff;
  logic [31:0]   m_addr_ff, m_wdata_ff, rdata_ff;
  logic [2:0]    m_cnt_ff;
  logic [2:0]    m_pulse_ff;
  logic          fr_o, fr_oe, ir_o, ir_oe, tr_o, tr_oe;
  logic          st_o, st_oe, dv_o, dv_oe;
  logic [AW-1:0] m_adc_o, m_adc_oe, t_adc_o, t_adc_oe;
  logic [4:0]    sts_o_ff, sts_oe_ff;
  logic [AW-1:0] adc_o_ff, adc_oe_ff;
  wire logic     m_wr = m_cmd_ff[0];

  // master sequencer: one data phase per request
  always_comb begin
    nxt_m_st = m_st_ff;
    fr_o = 1'b1; fr_oe = 1'b0; ir_o = 1'b1; ir_oe = 1'b0;
    m_adc_o = '0; m_adc_oe = '0;
    m_end = 1'b0; m_ok = 1'b0; m_abt = 1'b0; m_stp = 1'b0;
    case (m_st_ff)
      M_IDLE: if (m_pend_ff & ~pb.gnt_n & bus_idle) begin
        nxt_m_st = M_ADDR;
        fr_o = 1'b0; fr_oe = 1'b1; ir_oe = 1'b1;
        m_adc_o = {m_cmd_ff, m_addr_ff};
        m_adc_oe = '1;
      end
      M_ADDR, M_DATA: begin
        nxt_m_st = M_DATA;
        fr_oe = 1'b1;
        ir_o = 1'b0; ir_oe = 1'b1;
        m_adc_o = {m_be_ff, m_wdata_ff};
        m_adc_oe = {4'hF, {32{m_wr}}};
        if (m_st_ff == M_DATA) begin
          if (~trdy_n | ~stop_n) begin
            m_end = 1'b1;
            m_ok = ~trdy_n;
            m_stp = ~stop_n;
          end else if (devsel_n & (m_cnt_ff == DEVSEL_WAIT)) begin
            m_end = 1'b1;
            m_abt = 1'b1;
          end
        end
        if (m_end) begin
          nxt_m_st = M_REL;
          fr_oe = 1'b0;
          ir_o = 1'b1;
          m_adc_oe = '0;
        end
      end
      M_REL: nxt_m_st = M_IDLE;
      default: nxt_m_st = M_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (int_rst) begin
      m_pend_ff <= 1'b0;
    end else if (mst_start & ~m_pend_ff) begin
      m_pend_ff <= 1'b1;
    end else if (m_end) begin
      m_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (mst_start & ~m_pend_ff) begin
      m_cmd_ff   <= mst_cmd;
      m_addr_ff  <= mst_addr;
      m_wdata_ff <= mst_wdata;
      m_be_ff    <= mst_be_n;
    end
  end

  always_ff @(posedge mclk) begin
    if (int_rst | (m_st_ff != M_DATA)) begin
      m_cnt_ff <= 3'h0;
    end else if (m_cnt_ff != DEVSEL_WAIT) begin
      m_cnt_ff <= m_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (int_rst) begin
      rdata_ff   <= WORD_RST;
      m_pulse_ff <= 3'h0;
    end else begin
      m_pulse_ff <= {m_ok, m_abt, m_stp};
      if (m_ok & ~m_wr) begin
        rdata_ff <= ad_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic        fr_q_ff, t_cfg_ff, t_wr_ff, tgt_wr_ff;
  logic [31:0] word_ff, cfg_ff;
  wire logic   addr_ph  = ~frame_n & fr_q_ff & (m_st_ff != M_ADDR);
  wire logic   cfg_hit  = pb.idsel & (cbe_in[3:1] == CMD_CFG_HI);
  wire logic   mem_hit  = (cbe_in[3:1] == CMD_MEM_HI)
                        & (ad_in[31:24] == tgt_base);
  wire logic   t_cmp    = (t_st_ff == T_DATA) & ~irdy_n & ~trdy_n;
  wire logic   rd_sel   = (t_st_ff == T_IDLE) ? cfg_hit : t_cfg_ff;

  // target sequencer: fast decode, disconnect on a burst
  always_comb begin
    nxt_t_st = t_st_ff;
    tr_o = 1'b1; tr_oe = 1'b0; st_o = 1'b1; st_oe = 1'b0;
    dv_o = 1'b1; dv_oe = 1'b0;
    t_adc_o = {4'h0, rd_sel ? cfg_ff : word_ff};
    t_adc_oe = '0;
    case (t_st_ff)
      T_IDLE: if (addr_ph & (cfg_hit | mem_hit)) begin
        nxt_t_st = T_DATA;
        dv_o = 1'b0; dv_oe = 1'b1;
        tr_o = 1'b0; tr_oe = 1'b1; st_oe = 1'b1;
        t_adc_oe = {4'h0, {32{~cbe_in[0]}}};
      end
      T_DATA: begin
        dv_o = 1'b0; dv_oe = 1'b1; tr_oe = 1'b1; st_oe = 1'b1;
        if (frame_n & (t_cmp | irdy_n)) begin
          nxt_t_st = T_REL;
          dv_o = 1'b1;
        end else if (t_cmp) begin
          st_o = 1'b0;
        end else begin
          tr_o = sts_o_ff[C_TRDY];
          st_o = sts_o_ff[C_STOP];
          t_adc_oe = {4'h0, {32{~t_wr_ff & ~sts_o_ff[C_TRDY]}}};
        end
      end
      T_REL: nxt_t_st = T_IDLE;
      default: nxt_t_st = T_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (int_rst) begin
      t_cfg_ff  <= 1'b0;
      t_wr_ff   <= 1'b0;
      tgt_wr_ff <= 1'b0;
      word_ff   <= WORD_RST;
      cfg_ff    <= CFG_RST;
    end else begin
      tgt_wr_ff <= t_cmp & t_wr_ff;
      if (t_st_ff == T_IDLE) begin
        t_cfg_ff <= cfg_hit;
        t_wr_ff  <= cbe_in[0];
      end
      if (t_cmp & t_wr_ff & t_cfg_ff) begin
        cfg_ff <= pcipcf_merge(cfg_ff, ad_in, cbe_in);
      end
      if (t_cmp & t_wr_ff & ~t_cfg_ff) begin
        word_ff <= pcipcf_merge(word_ff, ad_in, cbe_in);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parking and bus drivers
  wire logic park_idle = ~pb.gnt_n & (m_st_ff == M_IDLE) & ~m_pend_ff
                       & bus_idle & (t_st_ff == T_IDLE);
  wire logic [AW-1:0] nxt_adc_oe =
    int_rst   ? {AW{cfn_s}} :
    park_idle ? '1 : (m_adc_oe | t_adc_oe);
  wire logic [AW-1:0] nxt_adc_o =
    (int_rst | park_idle) ? '0 : ((m_adc_o & m_adc_oe) | (t_adc_o & t_adc_oe));

  always_ff @(posedge mclk) begin
    if (int_rst) begin
      m_st_ff   <= M_IDLE;
      t_st_ff   <= T_IDLE;
      sts_o_ff  <= '1;
      sts_oe_ff <= '0;
      fr_q_ff   <= 1'b1;
    end else begin
      m_st_ff   <= nxt_m_st;
      t_st_ff   <= nxt_t_st;
      sts_o_ff  <= {dv_o, st_o, tr_o, ir_o, fr_o};
      sts_oe_ff <= {dv_oe, st_oe, tr_oe, ir_oe, fr_oe};
      fr_q_ff   <= frame_n;
    end
  end

  // not reset: parking while reset is held depends on the strap
  always_ff @(posedge mclk) begin
    adc_o_ff  <= nxt_adc_o;
    adc_oe_ff <= nxt_adc_oe;
  end

  ////////////////////////////////////////////////////////////////////////
  // parity: generate a clock late, check what this end received
  logic       par_o_ff, par_oe_ff, calc_ff, chkd_ff, chka_ff;
  logic [1:0] perr_st_ff;
  logic       serr_oe_ff, serr_irq_ff, rst_o_ff, inta_ff, req_ff;
  wire logic  rx_data = (t_cmp & t_wr_ff) | (m_ok & ~m_wr);
  wire logic  par_bad = calc_ff ^ par_in;

  always_ff @(posedge mclk) begin
    par_o_ff  <= ^pb.adc; // covers the master's byte enables too
    par_oe_ff <= adc_oe_ff[0] | adc_oe_ff[35];
    calc_ff   <= ^pb.adc;
    if (int_rst) begin
      chkd_ff     <= 1'b0;
      chka_ff     <= 1'b0;
      perr_st_ff  <= 2'h0;
      serr_oe_ff  <= 1'b0;
      serr_irq_ff <= 1'b0;
      inta_ff     <= 1'b0;
      req_ff      <= 1'b1;
    end else begin
      chkd_ff <= rx_data;
      chka_ff <= addr_ph;
      // low one clock, high one clock, then released
      perr_st_ff  <= (chkd_ff & par_bad) ? 2'h1 : {perr_st_ff[0], 1'b0};
      serr_oe_ff  <= ~cfn_s & (sw_serr | (chka_ff & par_bad));
      serr_irq_ff <= cfn_s & ~pb.ctl[C_SERR];
      inta_ff     <= doorbell_set | outbound_pending;
      req_ff      <= ~(m_pend_ff & (m_st_ff == M_IDLE));
    end
  end

  // kept out of reset so a driven pci reset cannot release itself
  always_ff @(posedge mclk) begin
    rst_o_ff <= prn_s & ~sw_pci_rst;
  end

  ////////////////////////////////////////////////////////////////////////
  assign pb.dev_adc_o   = adc_o_ff;
  assign pb.dev_adc_oe  = adc_oe_ff;
  assign pb.dev_ctl_o   = {1'b0, rst_o_ff, 1'b0, par_o_ff,
                           ~perr_st_ff[0], sts_o_ff};
  assign pb.dev_ctl_oe  = {inta_ff, cfn_s, serr_oe_ff, par_oe_ff,
                           |perr_st_ff, sts_oe_ff};
  // with the internal arbiter the pin carries the grant
  assign pb.req_n       = int_arb ? int_gnt_n : req_ff;

  assign processor_reset_n_o  = rst_n;
  assign processor_reset_n_oe = ~cfn_s;
  assign mst_busy    = m_pend_ff;
  assign mst_done    = m_pulse_ff[2];
  assign mst_abort   = m_pulse_ff[1];
  assign mst_stopped = m_pulse_ff[0];
  assign mst_rdata   = rdata_ff;
  assign tgt_wr      = tgt_wr_ff;
  assign tgt_word    = word_ff;
  assign tgt_cfg     = cfg_ff;
  assign strap_level = cfn_s;
  assign serr_irq    = serr_irq_ff;
  assign perr_seen   = perr_st_ff[0];
endmodule : pcipcf_dev

/* File: design/pcipcf_hst.sv */
// far-agent end: initiator, simple target, arbiter and central resource
`timescale 1ns/1ps
module pcipcf_hst
  import pcipcf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        cfn_strap,
  input  wire logic        int_arb,
  input  wire logic        host_rst_req,
  input  wire logic        serr_req,
  input  wire logic        h_start,
  input  wire logic        h_cfg,
  input  wire logic [3:0]  h_cmd,
  input  wire logic [31:0] h_addr,
  input  wire logic [31:0] h_wdata,
  output logic             h_busy,
  output logic             h_done,
  output logic             h_abort,
  output logic [31:0]      h_rdata,
  output logic [31:0]      h_word,
  output logic [2:0]       h_seen,
  pcipcf_if.hst            pb
);
  logic cfn_s;
  pcipcf_sync #(.W(1)) u_sync (.mclk(mclk), .d(cfn_strap), .q_ff(cfn_s));

  wire logic frame_n  = pb.ctl[C_FRAME];
  wire logic irdy_n   = pb.ctl[C_IRDY];
  wire logic trdy_n   = pb.ctl[C_TRDY];
  wire logic stop_n   = pb.ctl[C_STOP];
  wire logic bus_idle = frame_n & irdy_n;
  wire logic [31:0] ad_in  = pb.adc[31:0];

  ////////////////////////////////////////////////////////////////////////
  pcipcf_mst_e m_st_ff, nxt_m_st;
  pcipcf_tgt_e t_st_ff;
  logic [3:0]    cmd_ff;
  logic [31:0]   addr_ff, wdata_ff, rdata_ff, word_ff;
  logic [2:0]    cnt_ff;
  logic          pend_ff, cfg_ff, gnt_ff, gnt_q_ff, fr_q_ff, t_wr_ff;
  logic          m_end, m_ok, done_ff, abort_ff, hr_ff, par_o_ff, par_oe_ff;
  logic [4:0]    sts_o, sts_oe, sts_o_ff, sts_oe_ff;
  logic [AW-1:0] adc_o, adc_oe, adc_o_ff, adc_oe_ff;
  wire logic     wr = cmd_ff[0];
  wire logic     t_cmp = (t_st_ff == T_DATA) & ~irdy_n & ~trdy_n;
  wire logic     hit = ~frame_n & fr_q_ff & (m_st_ff != M_ADDR)
                     & (pb.adc[35:33] == CMD_MEM_HI)
                     & (ad_in[31:24] == HST_BASE);

  // master half, then the claim of the target half on the same lines
  always_comb begin
    nxt_m_st = m_st_ff;
    sts_o = 5'h1F; sts_oe = 5'h00; adc_o = '0; adc_oe = '0;
    m_end = 1'b0; m_ok = 1'b0;
    case (m_st_ff)
      M_IDLE: if (pend_ff & gnt_ff & gnt_q_ff & bus_idle) begin
        nxt_m_st = M_ADDR;
        sts_o[C_FRAME] = 1'b0; sts_oe[1:0] = 2'h3;
        adc_o = {cmd_ff, addr_ff}; adc_oe = '1;
      end
      M_ADDR, M_DATA: begin
        nxt_m_st = M_DATA;
        sts_o[C_IRDY] = 1'b0; sts_oe[1:0] = 2'h3;
        adc_o = {4'h0, wdata_ff}; adc_oe = {4'hF, {32{wr}}};
        if (m_st_ff == M_DATA) begin
          m_ok  = ~trdy_n;
          m_end = ~trdy_n | ~stop_n
                | (pb.ctl[C_DEVSEL] & (cnt_ff == DEVSEL_WAIT));
        end
        if (m_end) begin
          nxt_m_st = M_REL;
          sts_o[C_IRDY] = 1'b1; sts_oe[C_FRAME] = 1'b0; adc_oe = '0;
        end
      end
      M_REL: nxt_m_st = M_IDLE;
      default: nxt_m_st = M_IDLE;
    endcase
    if ((t_st_ff == T_IDLE & hit) | (t_st_ff == T_DATA & ~frame_n)) begin
      sts_o[4:2] = 3'b010; sts_oe[4:2] = 3'h7;
      adc_o = {4'h0, word_ff};
      adc_oe = {4'h0, {32{(t_st_ff == T_IDLE) ? ~pb.adc[32] : ~t_wr_ff}}};
    end else if (t_st_ff == T_DATA) begin
      sts_oe[4:2] = 3'h7; // drive high one clock before release
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      m_st_ff <= M_IDLE; t_st_ff <= T_IDLE;
      pend_ff <= 1'b0; cnt_ff <= 3'h0; fr_q_ff <= 1'b1;
      sts_o_ff <= 5'h1F; sts_oe_ff <= 5'h00; adc_oe_ff <= '0;
      gnt_ff <= 1'b1; gnt_q_ff <= 1'b1;
      done_ff <= 1'b0; abort_ff <= 1'b0; word_ff <= WORD_RST;
    end else begin
      m_st_ff <= nxt_m_st;
      if (t_st_ff == T_IDLE & hit) t_st_ff <= T_DATA;
      else if (t_st_ff == T_DATA & frame_n) t_st_ff <= T_IDLE;
      if (t_st_ff == T_IDLE) t_wr_ff <= pb.adc[32];
      if (t_cmp & t_wr_ff) word_ff <= pcipcf_merge(word_ff, ad_in,
                                                   pb.adc[35:32]);
      if (h_start & ~pend_ff) pend_ff <= 1'b1;
      else if (m_end) pend_ff <= 1'b0;
      cnt_ff <= (m_st_ff != M_DATA) ? 3'h0 :
                (cnt_ff == DEVSEL_WAIT) ? cnt_ff : cnt_ff + 3'h1;
      fr_q_ff <= frame_n;
      sts_o_ff <= sts_o; sts_oe_ff <= sts_oe; adc_oe_ff <= adc_oe;
      // high grant means the host side owns the bus
      gnt_ff <= ~(~pb.req_n & ~pend_ff & (m_st_ff == M_IDLE));
      gnt_q_ff <= gnt_ff;
      done_ff <= m_end & m_ok;
      abort_ff <= m_end & ~m_ok;
    end
  end

  always_ff @(posedge mclk) begin
    adc_o_ff  <= adc_o;
    par_o_ff  <= ^pb.adc;
    par_oe_ff <= adc_oe_ff[35] | adc_oe_ff[0];
    hr_ff     <= ~(srst | host_rst_req);
    h_seen    <= ~{pb.ctl[C_INTA], pb.ctl[C_PERR], pb.ctl[C_SERR]};
    if (h_start & ~pend_ff) begin
      cmd_ff <= h_cmd; addr_ff <= h_addr; wdata_ff <= h_wdata;
      cfg_ff <= h_cfg;
    end
    if (m_ok & ~wr) rdata_ff <= ad_in;
  end

  ////////////////////////////////////////////////////////////////////////
  assign pb.hst_adc_o  = adc_o_ff;
  assign pb.hst_adc_oe = adc_oe_ff;
  assign pb.hst_ctl_o  = {1'b0, hr_ff, 1'b0, par_o_ff, 1'b1, sts_o_ff};
  assign pb.hst_ctl_oe = {1'b0, ~cfn_s, cfn_s & serr_req, par_oe_ff, 1'b0,
                          sts_oe_ff};
  // internal arbiter: the request pin is looped back as grant
  assign pb.gnt_n  = int_arb ? pb.req_n : gnt_ff;
  assign pb.idsel  = cfg_ff & (m_st_ff == M_ADDR);
  assign h_busy  = pend_ff;
  assign h_done  = done_ff;
  assign h_abort = abort_ff;
  assign h_rdata = rdata_ff;
  assign h_word  = word_ff;
endmodule : pcipcf_hst

/* File: testbench/pcipcf_assertions.sv */
// concurrent checks on the pci wires joining the two ends
`timescale 1ns/1ps
module pcipcf_assertions
  import pcipcf_pkg::*;
(
  input wire logic          mclk,
  input wire logic          srst,
  input wire logic [CW-1:0] ctl,
  input wire logic [AW-1:0] adc,
  input wire logic          idsel,
  input wire logic          gnt_n,
  input wire logic [CW-1:0] dev_ctl_o,
  input wire logic [CW-1:0] dev_ctl_oe,
  input wire logic [AW-1:0] dev_adc_o,
  input wire logic [AW-1:0] dev_adc_oe
);
  logic [CW-1:0] dlo;
  wire           cfg_cmd = adc[35:33] == CMD_CFG_HI;
  // bits the bridge end is pulling low right now
  assign dlo = dev_ctl_oe & ~dev_ctl_o;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////////////////
  chk_par_even: assert property (
    &$past(dev_adc_oe) && dev_ctl_oe[C_PAR]
    |-> dev_ctl_o[C_PAR] == ^$past(dev_adc_o)) else $error("bad parity");
  // only the handshake lines and perr are sustained lines; par and serr are not
  chk_sts_release: assert property (
    !(|($past(dev_ctl_oe) & ~dev_ctl_oe & ~$past(dev_ctl_o) & 10'h03F)))
    else $error("line floated while low");
  chk_cfg_claim: assert property (
    $fell(ctl[C_FRAME]) && cfg_cmd && idsel |=> dlo[C_DEVSEL] && dlo[C_TRDY])
    else $error("config cycle not claimed");
  chk_cfg_no_idsel: assert property (
    $fell(ctl[C_FRAME]) && cfg_cmd && !idsel |=> !dev_ctl_oe[C_DEVSEL])
    else $error("config claimed without idsel");
  chk_claim_ready: assert property (
    $rose(dlo[C_DEVSEL]) |-> dlo[C_TRDY]) else $error("claim without trdy");
  chk_frame_grant: assert property (
    $rose(dlo[C_FRAME]) |-> !$past(gnt_n)) else $error("frame without grant");
  chk_one_phase: assert property (
    dlo[C_FRAME] |=> dlo[C_IRDY] && dev_ctl_oe[C_FRAME] && dev_ctl_o[C_FRAME])
    else $error("address phase not followed by data phase");
  chk_irdy_bound: assert property (
    $rose(dlo[C_IRDY]) |-> ##[1:7] !dlo[C_IRDY]) else $error("irdy stuck");
  chk_trdy_ends: assert property (
    dlo[C_IRDY] && !ctl[C_TRDY] |=> !dlo[C_IRDY]) else $error("no end on trdy");
  chk_perr_shape: assert property (
    $fell(dlo[C_PERR]) |-> dev_ctl_oe[C_PERR] && dev_ctl_o[C_PERR]
    ##1 !dev_ctl_oe[C_PERR]) else $error("perr not released high");
  cov_master: cover property ($rose(dlo[C_FRAME]));
  cov_target: cover property ($rose(dlo[C_DEVSEL]));
  cov_intr: cover property ($fell(ctl[C_INTA]));
endmodule : pcipcf_assertions

/* File: testbench/testbench.sv */
// directed tests of the bridge end against the far agent end
`timescale 1ns/1ps
module testbench;
  import pcipcf_pkg::*;
  `define CHK(n, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
    errors++; $display("mismatch %s exp %h got %h", n, ex, gt); end end
  logic        mclk, srst, cfn_strap, processor_reset_n_i, int_arb;
  logic        int_gnt_n, sw_serr, sw_pci_rst, doorbell_set;
  logic        outbound_pending, mst_start, mst_done, mst_abort;
  logic        processor_reset_n_o, processor_reset_n_oe, strap_level;
  logic        serr_irq, host_rst_req, serr_req, h_start, h_cfg;
  logic        h_done, h_abort, mst_busy;
  logic [2:0]  h_seen;
  logic [3:0]  mst_cmd, mst_be_n, h_cmd;
  logic [7:0]  tgt_base;
  logic [31:0] mst_addr, mst_wdata, mst_rdata, tgt_word, tgt_cfg;
  logic [31:0] h_addr, h_wdata, h_rdata, h_word;
  logic [1:0]  fin;
  int          errors, cmp_count;
  pcipcf_if bus();
  pcipcf_dev u_pcipcf_dev (.mclk, .srst, .cfn_strap, .processor_reset_n_i,
    .processor_reset_n_o, .processor_reset_n_oe, .int_arb, .int_gnt_n,
    .sw_serr, .sw_pci_rst, .doorbell_set, .outbound_pending, .mst_start,
    .mst_cmd, .mst_addr, .mst_wdata, .mst_be_n, .mst_busy, .mst_done,
    .mst_abort, .mst_stopped(), .mst_rdata, .tgt_base, .tgt_wr(), .tgt_word,
    .tgt_cfg, .strap_level, .serr_irq, .perr_seen(), .pb(bus));
  pcipcf_hst u_pcipcf_hst (.mclk, .srst, .cfn_strap, .int_arb, .host_rst_req,
    .serr_req, .h_start, .h_cfg, .h_cmd, .h_addr, .h_wdata, .h_busy(),
    .h_done, .h_abort, .h_rdata, .h_word, .h_seen, .pb(bus));
  pcipcf_assertions u_pcipcf_assertions (.mclk, .srst, .ctl(bus.ctl),
    .adc(bus.adc), .idsel(bus.idsel), .gnt_n(bus.gnt_n),
    .dev_ctl_o(bus.dev_ctl_o), .dev_ctl_oe(bus.dev_ctl_oe),
    .dev_adc_o(bus.dev_adc_o), .dev_adc_oe(bus.dev_adc_oe));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // waits for the end pulse of the master picked by dv (1 bridge, 0 host), {abort, done}
  task automatic wt(input bit dv);
    fin = 2'h0;
    for (int n = 0; n < 40 && fin == 2'h0; n++) begin
      tick();
      fin = dv ? {mst_abort, mst_done} : {h_abort, h_done};
    end
  endtask : wt
  task automatic dx(input logic [3:0] c, input logic [31:0] a, d);
    {mst_cmd, mst_addr, mst_wdata, mst_start} = {c, a, d, 1'b1};
    tick();
    mst_start = 1'b0;
    wt(1'b1);
  endtask : dx
  task automatic hx(input logic f, input logic [3:0] c,
                    input logic [31:0] a, d);
    {h_cfg, h_cmd, h_addr, h_wdata, h_start} = {f, c, a, d, 1'b1};
    tick();
    h_start = 1'b0;
    wt(1'b0);
  endtask : hx
  task automatic results;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  initial begin
    #(CLK_NS * 3000);
    errors++;
    results();
  end
  initial begin
    {srst, cfn_strap, processor_reset_n_i, int_gnt_n} = 4'hF;
    {int_arb, sw_serr, sw_pci_rst, doorbell_set, outbound_pending} = 5'h00;
    {mst_start, host_rst_req, serr_req, h_start, h_cfg} = 5'h00;
    {mst_cmd, mst_be_n, h_cmd, mst_addr, mst_wdata, h_addr, h_wdata} = '0;
    tgt_base = 8'h40;
    tick(10);
    `CHK("parked adc", 36'h0, bus.adc)
    `CHK("cpu rst oe", 1'b0, processor_reset_n_oe)
    srst = 1'b0;
    tick();
    `CHK("strap", 1'b1, strap_level)
    dx(4'h7, 32'h8000_0004, 32'hA5C3_0F12);
    `CHK("dev write end", 2'h1, fin)
    `CHK("host word", 32'hA5C3_0F12, h_word)
    `CHK("dev idle", 1'b0, mst_busy)
    dx(4'h6, 32'h8000_0004, 32'h0);
    `CHK("dev read", 32'hA5C3_0F12, mst_rdata)
    dx(4'h7, 32'h1000_0000, 32'h5);
    `CHK("unclaimed end", 2'h2, fin)
    hx(1'b0, 4'h7, 32'h4000_0010, 32'h1234_ABCD);
    `CHK("target word", 32'h1234_ABCD, tgt_word)
    hx(1'b1, 4'hB, 32'h0, 32'h0BAD_F00D);
    hx(1'b1, 4'hA, 32'h0, 32'h0);
    `CHK("cfg read", 32'h0BAD_F00D, h_rdata)
    hx(1'b0, 4'hB, 32'h0, 32'h1111_2222);
    `CHK("no idsel end", 2'h2, fin)
    `CHK("cfg kept", 32'h0BAD_F00D, tgt_cfg)
    {int_arb, int_gnt_n} = 2'h2;
    tick(2);
    `CHK("parked idle", 36'h0, bus.adc)
    dx(4'h7, 32'h8000_0008, 32'h5A5A_0001);
    `CHK("looped grant", 32'h5A5A_0001, h_word)
    {int_arb, int_gnt_n} = 2'h1;
    for (int i = 1; i < 4; i++) begin
      {doorbell_set, outbound_pending} = 2'(i);
      tick(3);
      `CHK("intr low", 1'b0, bus.ctl[C_INTA])
      `CHK("host intr", 1'b1, h_seen[2])
    end
    {doorbell_set, outbound_pending} = 2'h0;
    tick(3);
    `CHK("intr idle", 1'b1, bus.ctl[C_INTA])
    serr_req = 1'b1;
    tick(4);
    `CHK("serr irq", 1'b1, serr_irq)
    serr_req = 1'b0;
    sw_pci_rst = 1'b1;
    tick(5);
    `CHK("pci rst out", 1'b0, bus.ctl[C_RST])
    sw_pci_rst = 1'b0;
    cfn_strap = 1'b0;
    tick(6);
    `CHK("strap low", 1'b0, strap_level)
    sw_serr = 1'b1;
    tick(3);
    `CHK("serr out", 1'b0, bus.ctl[C_SERR])
    `CHK("host serr", 1'b1, h_seen[0])
    sw_serr = 1'b0;
    host_rst_req = 1'b1;
    tick(4);
    `CHK("cpu rst", 2'h1, {processor_reset_n_o, processor_reset_n_oe})
    host_rst_req = 1'b0;
    srst = 1'b1;
    tick(10);
    // no parking here, so the bus floats to the pull-up
    `CHK("unparked adc", 36'hF_FFFF_FFFF, bus.adc)
    srst = 1'b0;
    tick(4);
    results();
  end
endmodule : testbench
